// [include/epsr_pkg.sv]
// constants for the extended page and serdes control register bank
// assumes a 32-bit apb master and the register file clock
package epsr_pkg;
    // management register indices (byte address is four times the index)
    localparam logic [4:0] REG_16 = 5'h10;
    localparam logic [4:0] REG_17 = 5'h11;
    localparam logic [4:0] REG_18 = 5'h12;
    localparam logic [4:0] REG_19 = 5'h13;
    localparam logic [4:0] REG_20 = 5'h14;
    localparam logic [4:0] REG_21 = 5'h15;
    localparam logic [4:0] REG_22 = 5'h16;
    localparam logic [4:0] REG_23 = 5'h17;
    localparam logic [4:0] REG_27 = 5'h1B;
    localparam logic [4:0] REG_28 = 5'h1C;
    localparam logic [4:0] REG_29 = 5'h1D;
    localparam logic [4:0] REG_30 = 5'h1E;
    localparam logic [4:0] REG_PAGE = 5'h1F;
    localparam logic [4:0] EXT_FIRST = 5'h10;
    // own block registers, beyond the management space
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h80;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h84;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h88;
    localparam logic [7:0] ADDR_MGMT_LIMIT = 8'h80;
    // page codes
    localparam logic [15:0] PAGE_MAIN = 16'h0000;
    localparam logic [15:0] PAGE_EXT = 16'h0001;
    localparam logic [15:0] PAGE_GPIO = 16'h0010;
    localparam logic [15:0] PAGE_RESET = 16'h0000;
    // 16E fields
    localparam int TXRF_HI = 15;
    localparam int TXRF_LO = 14;
    localparam int LPRF_HI = 13;
    localparam int LPRF_LO = 12;
    localparam int PDET_BIT = 11;
    localparam int SDET_BIT = 10;
    localparam int ALLOW_X_BIT = 9;
    localparam int ALLOW_FX_BIT = 8;
    localparam int LPRST_BIT = 7;
    localparam int FEF_BIT = 6;
    localparam logic [15:0] R16_WMASK = 16'hCB00;
    localparam logic [15:0] R16_RESET = 16'h0300;
    // 17E fields
    localparam int MEQ_BIT = 9;
    localparam int CEQ_BIT = 8;
    localparam int MSW_HI = 7;
    localparam int MSW_LO = 5;
    localparam int CSW_HI = 4;
    localparam int CSW_LO = 2;
    localparam int CHYS_BIT = 1;
    localparam int MHYS_BIT = 0;
    localparam logic [15:0] R17_WMASK = 16'h03FF;
    localparam logic [15:0] R17_RESET = 16'h0090;
    localparam logic [2:0] SWING_MAX = 3'h5;
    // interrupt bits
    localparam int IRQ_LPRST = 0;
    localparam int IRQ_FEF = 1;
    localparam int IRQ_W = 2;
endpackage

// [design/epsr_regs.sv]
// extended page select and serdes control register bank, apb slave
// assumes status inputs come from other clock domains or pins
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module epsr_regs (
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic [1:0] I_LP_REMOTE_FAULT,
    input wire logic I_SIGNAL_DETECT,
    input wire logic I_LP_RESTART_REQ,
    input wire logic I_FAR_END_FAULT,
    output logic O_MAIN_SEL,
    output logic O_EXT_SEL,
    output logic O_GPIO_SEL,
    output logic [4:0] O_MGMT_IDX,
    output logic O_MGMT_WR,
    output logic O_MGMT_RD,
    output logic [15:0] O_MGMT_WDATA,
    input wire logic [15:0] I_MAIN_RDATA,
    input wire logic [15:0] I_EXT_RDATA,
    input wire logic [15:0] I_GPIO_RDATA,
    output logic [1:0] O_TX_REMOTE_FAULT,
    output logic O_PARALLEL_DETECT,
    output logic O_ALLOW_1000X,
    output logic O_ALLOW_100FX,
    output logic O_MEDIA_EQ_EN,
    output logic O_MAC_EQ_EN,
    output logic [2:0] O_MEDIA_SWING,
    output logic [2:0] O_MAC_SWING,
    output logic O_MAC_HYST_DIS,
    output logic O_MEDIA_HYST_DIS,
    output logic O_IRQ
);
    // ============================================================
    // input synchronisers
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
        end else begin
            sync1_reg <= {I_LP_REMOTE_FAULT, I_SIGNAL_DETECT, I_LP_RESTART_REQ,
                          I_FAR_END_FAULT};
            sync2_reg <= sync1_reg;
        end
    end
    wire logic [1:0] lp_rf = sync2_reg[4:3];
    wire logic sig_det = sync2_reg[2];
    wire logic lp_rst = sync2_reg[1];
    wire logic fef = sync2_reg[0];

    // ============================================================
    // apb decode; zero wait states
    // an own register answers only at its exact, word-aligned byte address
    function automatic logic word_at(input logic [7:0] a, input logic [7:0] w);
        return (a[1:0] == 2'h0) && (a == w);
    endfunction

    wire logic acc = I_PSEL && I_PENABLE;
    wire logic wr = acc && I_PWRITE;
    wire logic rd = acc && !I_PWRITE;
    wire logic rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
    wire logic aligned = (I_PADDR[1:0] == 2'h0);
    wire logic mgmt_hit = aligned && (I_PADDR < epsr_pkg::ADDR_MGMT_LIMIT);
    wire logic [4:0] idx = I_PADDR[6:2];
    wire logic hit_sts = word_at(I_PADDR, epsr_pkg::ADDR_IRQ_STATUS);
    wire logic hit_en = word_at(I_PADDR, epsr_pkg::ADDR_IRQ_ENABLE);
    wire logic hit_clr = word_at(I_PADDR, epsr_pkg::ADDR_IRQ_CLEAR);
    wire logic mapped = mgmt_hit || hit_sts || hit_en || hit_clr;

    logic [15:0] page_reg;
    logic [15:0] page_next;
    wire logic is_page = mgmt_hit && (idx == epsr_pkg::REG_PAGE);
    wire logic pg_ext = (page_reg == epsr_pkg::PAGE_EXT);
    wire logic pg_gpio = (page_reg == epsr_pkg::PAGE_GPIO);
    // undefined page codes fall back to the main space, the safe choice
    wire logic upper = (idx >= epsr_pkg::EXT_FIRST);
    wire logic to_gpio = mgmt_hit && !is_page && pg_gpio;
    wire logic to_ext = mgmt_hit && !is_page && pg_ext && upper;
    wire logic to_main = mgmt_hit && !is_page && !to_gpio && !to_ext;

    // ============================================================
    // extended decode
    wire logic e16 = to_ext && (idx == epsr_pkg::REG_16);
    wire logic e17 = to_ext && (idx == epsr_pkg::REG_17);
    wire logic e_rsvd = to_ext && ((idx == epsr_pkg::REG_21) || (idx == epsr_pkg::REG_22)
                        || (idx == epsr_pkg::REG_27)
                        || ((idx > epsr_pkg::REG_23) && (idx < epsr_pkg::REG_27)));
    // functional extended registers other than 16E/17E live outside this block
    wire logic e_far = to_ext && !e16 && !e17 && !e_rsvd;

    // ============================================================
    // page register
    assign page_next = (wr && is_page) ? I_PWDATA[15:0] : page_reg;
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            page_reg <= epsr_pkg::PAGE_RESET;
        end else begin
            page_reg <= page_next;
        end
    end

    // ============================================================
    // 16E and 17E
    logic [15:0] r16_reg;
    logic [15:0] r16_next;
    logic [15:0] r17_reg;
    logic [15:0] r17_next;
    logic lprst_reg;
    logic fef_reg;
    wire logic rd16 = rd && e16;
    wire logic [15:0] w16 = (I_PWDATA[15:0] & epsr_pkg::R16_WMASK)
                            | (r16_reg & ~epsr_pkg::R16_WMASK);
    assign r16_next = (wr && e16) ? w16 : r16_reg;
    // reserved swing codes are kept as written; the serdes treats them as such
    wire logic [15:0] w17 = I_PWDATA[15:0] & epsr_pkg::R17_WMASK;
    assign r17_next = (wr && e17) ? w17 : r17_reg;
    // event set wins over the clear from a read in the same cycle
    // data is captured a cycle before the clear: only a flag the host saw is cleared,
    // so an event landing between setup and access is not lost
    wire logic shown_rst = O_PRDATA[epsr_pkg::LPRST_BIT];
    wire logic shown_fef = O_PRDATA[epsr_pkg::FEF_BIT];
    wire logic lprst_next = lp_rst || (lprst_reg && !(rd16 && shown_rst));
    wire logic fef_next = fef || (fef_reg && !(rd16 && shown_fef));
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            r16_reg <= epsr_pkg::R16_RESET;
            r17_reg <= epsr_pkg::R17_RESET;
            lprst_reg <= 1'b0;
            fef_reg <= 1'b0;
        end else begin
            r16_reg <= r16_next;
            r17_reg <= r17_next;
            lprst_reg <= lprst_next;
            fef_reg <= fef_next;
        end
    end
    wire logic [15:0] r16_view = {r16_reg[epsr_pkg::TXRF_HI:epsr_pkg::TXRF_LO], lp_rf,
                                  r16_reg[epsr_pkg::PDET_BIT], sig_det,
                                  r16_reg[epsr_pkg::ALLOW_X_BIT:epsr_pkg::ALLOW_FX_BIT],
                                  lprst_reg, fef_reg, 6'h00};

    // ============================================================
    // interrupts: sticky status, enable, write-one-to-clear
    logic [epsr_pkg::IRQ_W-1:0] ists_reg;
    logic [epsr_pkg::IRQ_W-1:0] ists_next;
    logic [epsr_pkg::IRQ_W-1:0] ien_reg;
    wire logic [epsr_pkg::IRQ_W-1:0] iev = {fef, lp_rst};
    wire logic [epsr_pkg::IRQ_W-1:0] iclr = (wr && hit_clr) ?
                                             I_PWDATA[epsr_pkg::IRQ_W-1:0] : '0;
    assign ists_next = iev | (ists_reg & ~iclr);
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            ists_reg <= '0;
            ien_reg <= '0;
        end else begin
            ists_reg <= ists_next;
            if (wr && hit_en) begin
                ien_reg <= I_PWDATA[epsr_pkg::IRQ_W-1:0];
            end
        end
    end
    assign O_IRQ = |(ists_reg & ien_reg);

    // ============================================================
    // read mux and outward strobes
    wire logic [15:0] mgmt_rd = is_page ? page_reg
                              : e16 ? r16_view
                              : e17 ? r17_reg
                              : e_rsvd ? 16'h0000
                              : e_far ? I_EXT_RDATA
                              : to_gpio ? I_GPIO_RDATA
                              : I_MAIN_RDATA;
    wire logic [31:0] rdata = mgmt_hit ? {16'h0000, mgmt_rd}
                            : hit_sts ? {30'h00000000, ists_reg}
                            : hit_en ? {30'h00000000, ien_reg}
                            : 32'h00000000;
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            O_PRDATA <= 32'h00000000;
        end else if (rd_setup) begin
            O_PRDATA <= rdata;
        end
    end
    // data is captured in the setup phase so prdata is a flop at the access edge
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = acc && !mapped;
    wire logic fwd = to_main || to_gpio || e_far;
    assign O_MAIN_SEL = to_main;
    assign O_EXT_SEL = e_far;
    assign O_GPIO_SEL = to_gpio;
    assign O_MGMT_IDX = idx;
    assign O_MGMT_WR = wr && fwd;
    assign O_MGMT_RD = rd_setup && fwd;
    assign O_MGMT_WDATA = I_PWDATA[15:0];

    assign O_TX_REMOTE_FAULT = r16_reg[epsr_pkg::TXRF_HI:epsr_pkg::TXRF_LO];
    assign O_PARALLEL_DETECT = r16_reg[epsr_pkg::PDET_BIT];
    assign O_ALLOW_1000X = r16_reg[epsr_pkg::ALLOW_X_BIT];
    assign O_ALLOW_100FX = r16_reg[epsr_pkg::ALLOW_FX_BIT];
    assign O_MEDIA_EQ_EN = r17_reg[epsr_pkg::MEQ_BIT];
    assign O_MAC_EQ_EN = r17_reg[epsr_pkg::CEQ_BIT];
    assign O_MEDIA_SWING = r17_reg[epsr_pkg::MSW_HI:epsr_pkg::MSW_LO];
    assign O_MAC_SWING = r17_reg[epsr_pkg::CSW_HI:epsr_pkg::CSW_LO];
    assign O_MAC_HYST_DIS = r17_reg[epsr_pkg::CHYS_BIT];
    assign O_MEDIA_HYST_DIS = r17_reg[epsr_pkg::MHYS_BIT];

    // ============================================================
    // assertions
    a_page_write: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        wr && is_page |=> page_reg == $past(I_PWDATA[15:0]))
        else $error("page register not updated");
    a_ext_steer: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        mgmt_hit && !is_page && pg_ext && idx >= epsr_pkg::EXT_FIRST |-> !O_MAIN_SEL)
        else $error("extended access reached main space");
    a_low_main: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        mgmt_hit && idx < epsr_pkg::EXT_FIRST && !pg_gpio |-> O_MAIN_SEL)
        else $error("low register not in main space");
    a_gpio_steer: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        mgmt_hit && !is_page && pg_gpio |-> O_GPIO_SEL && !O_MAIN_SEL)
        else $error("gpio page not steered");
    a_rsvd_quiet: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        e_rsvd |-> !O_MGMT_WR && !O_MGMT_RD && !O_EXT_SEL)
        else $error("reserved extended register forwarded");
    a_rst_clear: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        lprst_reg && rd16 && shown_rst && !lp_rst |=> !lprst_reg)
        else $error("restart flag not cleared by read");
    a_rst_set: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        lp_rst |=> lprst_reg && ists_reg[epsr_pkg::IRQ_LPRST])
        else $error("restart request lost");
    a_fef_hold: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        fef_reg && !rd16 |=> fef_reg)
        else $error("far end fault dropped without read");
    a_rsvd_zero: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        r16_reg[5:0] == 6'h00 && r17_reg[15:10] == 6'h00)
        else $error("reserved bits set");
    a_reset_vals: assert property (@(posedge I_CLOCK)
        !I_NRST |=> page_reg == epsr_pkg::PAGE_RESET && O_MEDIA_SWING == 3'h4
                    && O_ALLOW_1000X && O_ALLOW_100FX)
        else $error("reset values wrong");
    a_irq_level: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        $rose(O_IRQ) |-> |(ists_reg & ien_reg))
        else $error("irq without enabled status");

    // ============================================================
    // field assertions
    a_rf_report: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        rd_setup && e16 |=> O_PRDATA[epsr_pkg::LPRF_HI:epsr_pkg::LPRF_LO] == $past(lp_rf))
        else $error("partner remote fault not reported");
    a_sdet_report: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        rd_setup && e16 |=> O_PRDATA[epsr_pkg::SDET_BIT] == $past(sig_det))
        else $error("signal detect not reported");
    a_txrf_write: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        wr && e16 |=> O_TX_REMOTE_FAULT == $past(I_PWDATA[epsr_pkg::TXRF_HI:epsr_pkg::TXRF_LO]))
        else $error("transmit remote fault not written");
    a_pdet_write: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        wr && e16 |=> O_PARALLEL_DETECT == $past(I_PWDATA[epsr_pkg::PDET_BIT]))
        else $error("parallel detect not written");
    a_allow_hold: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        !(wr && e16) |=> $stable(O_ALLOW_1000X) && $stable(O_ALLOW_100FX))
        else $error("allow bits changed without write");
    a_eq_write: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        wr && e17 |=> O_MEDIA_EQ_EN == $past(I_PWDATA[epsr_pkg::MEQ_BIT])
                      && O_MAC_EQ_EN == $past(I_PWDATA[epsr_pkg::CEQ_BIT]))
        else $error("equalization enables not written");
    a_swing_write: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        wr && e17 |=> O_MEDIA_SWING == $past(I_PWDATA[epsr_pkg::MSW_HI:epsr_pkg::MSW_LO])
                      && O_MAC_SWING == $past(I_PWDATA[epsr_pkg::CSW_HI:epsr_pkg::CSW_LO]))
        else $error("swing fields not written");
    a_hyst_write: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        wr && e17 |=> O_MAC_HYST_DIS == $past(I_PWDATA[epsr_pkg::CHYS_BIT])
                      && O_MEDIA_HYST_DIS == $past(I_PWDATA[epsr_pkg::MHYS_BIT]))
        else $error("hysteresis bits not written");
    a_fef_set: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        fef |=> fef_reg && ists_reg[epsr_pkg::IRQ_FEF])
        else $error("far end fault lost");
    a_rsvd_read: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        rd_setup && e_rsvd |=> O_PRDATA == 32'h00000000)
        else $error("reserved extended register read nonzero");
    a_rsvd_ignore: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        wr && e_rsvd |=> $stable(r16_reg) && $stable(r17_reg))
        else $error("reserved write changed a register");
    a_page_read: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        rd_setup && is_page |=> O_PRDATA[15:0] == $past(page_reg))
        else $error("page register read wrong");
    a_page_keep: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        !(wr && is_page) |=> $stable(page_reg))
        else $error("page changed without write");
    a_gpio_low: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        mgmt_hit && pg_gpio && idx < epsr_pkg::EXT_FIRST |-> O_GPIO_SEL)
        else $error("low register not in gpio space");
    a_ext_low: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        mgmt_hit && pg_ext && idx < epsr_pkg::EXT_FIRST |-> O_MAIN_SEL)
        else $error("low register left main space");

    // ============================================================
    // bus and interrupt assertions
    a_no_select: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        !mgmt_hit |-> !O_MAIN_SEL && !O_EXT_SEL && !O_GPIO_SEL)
        else $error("space selected off the management map");
    a_wr_strobe: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        O_MGMT_WR |-> wr)
        else $error("write strobe outside write access");
    a_slverr_phase: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        O_PSLVERR |-> acc)
        else $error("error outside access phase");
    a_irq_clear: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        wr && hit_clr && I_PWDATA[epsr_pkg::IRQ_LPRST] && !lp_rst
        |=> !ists_reg[epsr_pkg::IRQ_LPRST])
        else $error("status bit not cleared");
    a_ien_write: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        wr && hit_en |=> ien_reg == $past(I_PWDATA[epsr_pkg::IRQ_W-1:0]))
        else $error("irq enable not written");
    c_ext_write: cover property (@(posedge I_CLOCK) wr && e16);
    c_gpio_read: cover property (@(posedge I_CLOCK) rd && to_gpio);
    c_clear_race: cover property (@(posedge I_CLOCK) rd16 && lp_rst && lprst_reg);
    c_irq: cover property (@(posedge I_CLOCK) $rose(O_IRQ));
    c_late_event: cover property (@(posedge I_CLOCK) rd16 && lprst_reg && !shown_rst);
endmodule

// [tb/epsr_far_model.sv]
// far side of the bank: main, extended and gpio register spaces
// assumes the bank selects one space at a time from its current address
`timescale 1ns/1ps
module epsr_far_model (
    input wire logic i_main_sel,
    input wire logic i_ext_sel,
    input wire logic i_gpio_sel,
    input wire logic [4:0] i_idx,
    output logic [15:0] o_main_rdata,
    output logic [15:0] o_ext_rdata,
    output logic [15:0] o_gpio_rdata
);
    // =====================================================
    // read data patterns
    // each space answers with its own tag and the index; an unselected
    // space shows the inverse so a wrong steering never reads as a match
    wire [15:0] main_pat = {8'hA0, 3'h0, i_idx};
    wire [15:0] ext_pat = {8'hE0, 3'h0, i_idx};
    wire [15:0] gpio_pat = {8'h60, 3'h0, i_idx};
    assign o_main_rdata = i_main_sel ? main_pat : ~main_pat;
    assign o_ext_rdata = i_ext_sel ? ext_pat : ~ext_pat;
    assign o_gpio_rdata = i_gpio_sel ? gpio_pat : ~gpio_pat;
endmodule

// [tb/test_extended_page_serdes_ctrl_regs.sv]
// self-checking bench for the page select and serdes control bank
// assumes a zero-wait apb slave and a 2-flop sync on status inputs
`timescale 1ns/1ps
module test_extended_page_serdes_ctrl_regs;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [1:0] lprf = 2'h0;
    logic sdet = 1'b0;
    logic rreq = 1'b0;
    logic fef = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, irq, msel, esel, gsel;
    wire [4:0] idx;
    wire [15:0] mrd, erd, grd;
    wire [1:0] txrf;
    wire [2:0] msw, csw;
    wire pdet, a1000, a100, meq, ceq, chys, mhys;
    wire mwr, mrds;
    wire [15:0] mwd;
    int wcnt = 0;
    int rcnt = 0;
    logic [15:0] lastwd = 16'h0000;
    // count forwarded strobes so steering is seen from the outside
    always @(posedge clk) begin
        if (mwr) begin
            wcnt++;
            lastwd = mwd;
        end
        if (mrds)
            rcnt++;
    end
    wire [4:0] ctl16 = {txrf, pdet, a1000, a100};
    wire [9:0] ctl17 = {meq, ceq, msw, csw, chys, mhys};
    int failures = 0;
    int checks = 0;
    always #5 clk = ~clk;
    // =====================================================
    // design and far side
    epsr_regs i_dut (.I_CLOCK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_LP_REMOTE_FAULT(lprf),
        .I_SIGNAL_DETECT(sdet), .I_LP_RESTART_REQ(rreq), .I_FAR_END_FAULT(fef),
        .O_MAIN_SEL(msel), .O_EXT_SEL(esel), .O_GPIO_SEL(gsel), .O_MGMT_IDX(idx),
        .O_MGMT_WR(mwr), .O_MGMT_RD(mrds), .O_MGMT_WDATA(mwd), .I_MAIN_RDATA(mrd),
        .I_EXT_RDATA(erd), .I_GPIO_RDATA(grd), .O_TX_REMOTE_FAULT(txrf),
        .O_PARALLEL_DETECT(pdet), .O_ALLOW_1000X(a1000), .O_ALLOW_100FX(a100),
        .O_MEDIA_EQ_EN(meq), .O_MAC_EQ_EN(ceq), .O_MEDIA_SWING(msw), .O_MAC_SWING(csw),
        .O_MAC_HYST_DIS(chys), .O_MEDIA_HYST_DIS(mhys), .O_IRQ(irq));
    epsr_far_model i_far (.i_main_sel(msel), .i_ext_sel(esel), .i_gpio_sel(gsel),
        .i_idx(idx), .o_main_rdata(mrd), .o_ext_rdata(erd), .o_gpio_rdata(grd));
    // =====================================================
    // bus and compare tasks
    task results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one idle edge first, so psel never toggles twice in one step
    task apb(input logic w, input logic [7:0] a, input logic [15:0] d,
             output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            $display("BAD %0t no ready", $time);
            results;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        @(negedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 16'h0000, r, e);
        chk(r, exp, what);
    endtask
    // =====================================================
    // scenarios
    task t_reset;
        chk({27'h0, ctl16}, 32'h3, "16E outputs at reset");
        chk({22'h0, ctl17}, 32'h090, "17E outputs at reset");
        rd(8'h7C, 32'h0, "page at reset");
        rd(8'h40, 32'h0000A010, "main 16 at reset");
        wr(8'h7C, 16'h0001);
        rd(8'h40, 32'h00000300, "16E reset");
        rd(8'h44, 32'h00000090, "17E reset");
        $display("t_reset done");
    endtask
    task t_pages;
        rd(8'h14, 32'h0000A005, "low reg on ext page");
        rd(8'h48, 32'h0000E012, "18E forwarded");
        rd(8'h54, 32'h0, "21E reserved");
        rd(8'h58, 32'h0, "22E reserved");
        rd(8'h6C, 32'h0, "27E reserved");
        chk(rcnt, 32'h3, "forwarded reads counted");
        wr(8'h54, 16'hFFFF);
        chk(wcnt, 32'h0, "21E write not forwarded");
        rd(8'h54, 32'h0, "21E ignores writes");
        wr(8'h7C, 16'h0010);
        rd(8'h7C, 32'h00000010, "page readback");
        rd(8'h14, 32'h00006005, "gpio low reg");
        rd(8'h78, 32'h0000601E, "gpio reg 30");
        wr(8'h7C, 16'h0000);
        rd(8'h40, 32'h0000A010, "main restored");
        wr(8'h40, 16'h1234);
        chk({16'h0, lastwd}, 32'h1234, "main write forwarded");
        $display("t_pages done");
    endtask
    task t_fields;
        wr(8'h7C, 16'h0001);
        wr(8'h40, 16'h0000);
        chk({27'h0, ctl16}, 32'h0, "allow bits cleared");
        wr(8'h40, 16'hFFFF);
        rd(8'h40, 32'h0000CB00, "16E all ones");
        chk({27'h0, ctl16}, 32'h1F, "16E outputs set");
        wr(8'h44, 16'hFFFF);
        rd(8'h44, 32'h000003FF, "17E all ones");
        chk({22'h0, ctl17}, 32'h3FF, "17E outputs set");
        wr(8'h44, 16'h02B4);
        chk({22'h0, ctl17}, 32'h2B4, "17E top swing code");
        $display("t_fields done");
    endtask
    task t_status;
        wr(8'h84, 16'h0003);
        @(posedge clk);
        lprf <= 2'h2;
        sdet <= 1'b1;
        rreq <= 1'b1;
        fef <= 1'b1;
        @(posedge clk);
        rreq <= 1'b0;
        fef <= 1'b0;
        // second sync flop and flag set take two of these edges, the other two are margin
        repeat (4) @(posedge clk);
        chk({31'h0, irq}, 32'h1, "irq raised");
        rd(8'h40, 32'h0000EFC0, "16E status");
        rd(8'h40, 32'h0000EF00, "flags clear on read");
        rd(8'h80, 32'h00000003, "irq status");
        wr(8'h84, 16'h0000);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(8'h84, 16'h0003);
        wr(8'h88, 16'h0003);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        rd(8'h80, 32'h0, "irq status cleared");
        $display("t_status done");
    endtask
    task t_refuse;
        logic [31:0] r;
        logic e;
        apb(1'b0, 8'h8C, 16'h0000, r, e);
        chk({31'h0, e}, 32'h1, "unmapped error");
        chk(r, 32'h0, "unmapped data");
        apb(1'b1, 8'h41, 16'h0000, r, e);
        chk({31'h0, e}, 32'h1, "unaligned error");
        rd(8'h40, 32'h0000EF00, "unaligned write ignored");
        $display("t_refuse done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
        t_pages;
        t_fields;
        t_status;
        t_refuse;
        results;
    end
endmodule
